//--- src/irf_pkg.sv
// Package: register map, field layout, reset values and types of the request flag block
package irf_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PRI  = 8'h00;  // Pending flags, primary
  localparam logic [7:0] OFS_SEC  = 8'h04;  // Pending flags, secondary
  localparam logic [7:0] OFS_ENP  = 8'h08;  // Enable register, primary
  localparam logic [7:0] OFS_ENS  = 8'h0c;  // Enable register, secondary
  localparam logic [7:0] OFS_EDGE = 8'h10;  // Edge select, one bit per pin
  localparam logic [7:0] OFS_CTRL = 8'h14;  // System control: transition and pin function

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_DT       = 7;  // Direct transition pending
  localparam int BIT_RTC      = 6;  // Real-time clock overflow pending
  localparam int BIT_TB1      = 5;  // Timer B1 overflow pending
  localparam int NPINS        = 4;  // External request pins
  localparam int CTRL_DIRECT_TRANSITION_ENABLE    = 0;  // Direct transition enable
  localparam int CTRL_PIN_LSB = 4;  // Pin-as-interrupt-input bits 7:4

  // ---------------------------------------------------------------
  // Bit layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PRI_MASK  = 8'hcf;  // Live bits of primary layout
  localparam logic [7:0] PRI_ONES  = 8'h30;  // Reserved bits reading 1
  localparam logic [7:0] SEC_MASK  = 8'h20;  // Live bits of secondary layout
  localparam logic [7:0] SEC_ONES  = 8'h1f;  // Reserved bits reading 1
  localparam logic [7:0] CTRL_MASK = 8'hf1;  // Live control bits
  localparam logic [7:0] RST_FLAGS = 8'h00;  // Flags after reset
  localparam logic [7:0] RST_CFG   = 8'h00;  // Enables, edges, control after reset

  // ---------------------------------------------------------------
  // Bus encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;  // Only NONSEQ and SEQ carry a transfer
  localparam logic       HRESP_OKAY    = 1'h0;  // Only response given

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // On-chip event pulses, one clock wide, same clock domain
  typedef struct packed {
    logic sleep_direct;  // Sleep caused a direct mode transition
    logic rtc_ovf;       // Real-time clock counter overflow
    logic tb1_ovf;       // Timer B1 counter overflow
  } irf_evt_t;

  // Data phase of the bus slave
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WR   = 3'b010,
    PH_RD   = 3'b100
  } irf_phase_t;

endpackage : irf_pkg

//--- src/irf_top.sv
// Module: interrupt request flag registers behind an AHB-Lite slave
//
// Behaviour
// - Direct transition with enable sets bit 7
// - Clock counter overflow sets primary bit 6
// - Selected pin edge sets pin flag 3..0
// - Timer B1 overflow sets secondary bit 5
// - Writing 0 to a flag clears it
// - Primary 5:4, secondary 4:0 read one
// - Secondary bits 7:6 always read zero
// - All request flags reset to zero
// - Per-pin edge select: rising or falling
// - Request raised only when matching enable set
//
// The address map and the AHB-Lite interface to the registers were decided locally.
module irf_top (
  input  wire logic            CLK,         // System clock, 250 MHz
  input  wire logic            RESET_N,     // Asynchronous reset, active low
  input  wire logic            HSEL,        // Slave select
  input  wire logic [31:0]     HADDR,       // Byte address
  input  wire logic [1:0]      HTRANS,      // Transfer type
  input  wire logic            HWRITE,      // Write when high
  input  wire logic [2:0]      HSIZE,       // Word transfers only
  input  wire logic [31:0]     HWDATA,      // Write data, data phase
  input  wire logic            HREADY,      // Bus ready
  output logic      [31:0]     HRDATA,      // Read data, registered
  output logic                 HREADYOUT,   // Never stalls
  output logic                 HRESP,       // Always OKAY
  input  wire logic [3:0]      EXT_REQ_PIN, // External request pins, asynchronous
  input  wire irf_pkg::irf_evt_t EVENTS,    // On-chip event pulses
  output logic                 INT_REQ      // Level request to the CPU
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Visible value of a register: live bits plus fixed ones
  function automatic logic [7:0] fn_view(input logic [7:0] v, input logic [7:0] m,
                                         input logic [7:0] o);
    fn_view = (v & m) | o;
  endfunction : fn_view

  // Flag update: set wins over a clearing write of zero
  function automatic logic [7:0] fn_flag(input logic [7:0] cur, input logic [7:0] set,
                                         input logic [7:0] clr, input logic [7:0] m);
    fn_flag = ((cur & ~clr) | set) & m;
  endfunction : fn_flag

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  irf_pkg::irf_phase_t phase_reg, phase_next;  // Data phase kind
  logic [7:0]  addr_reg, addr_next;            // Address captured in address phase
  logic [31:0] rdata_reg, rdata_next;          // Read data
  logic        ready_reg, resp_reg;            // Bus handshake outputs
  logic [7:0]  pri_reg, pri_next;              // Pending flags, primary
  logic [7:0]  sec_reg, sec_next;              // Pending flags, secondary
  logic [7:0]  enp_reg, enp_next;              // Enables, primary
  logic [7:0]  ens_reg, ens_next;              // Enables, secondary
  logic [3:0]  edge_reg, edge_next;            // 1 = rising edge
  logic [7:0]  ctrl_reg, ctrl_next;            // Control bits
  logic [3:0]  sync1_reg, sync2_reg, prev_reg; // Pin synchroniser and history
  logic        int_reg, int_next;              // Interrupt request output

  // Combinational helpers
  logic        accept;                         // Address phase taken
  logic        wr_en;                          // Write data phase live
  logic [3:0]  pin_hit;                        // Selected edge seen on enabled pin
  logic [7:0]  set_pri, set_sec;               // Hardware set terms
  logic [7:0]  clr_wr;                         // Zeros written to live bits

  // ---------------------------------------------------------------
  // Bus address phase
  // ---------------------------------------------------------------
  // Capture the transfer; answer is always zero wait states
  always_comb begin
    accept     = HSEL && HREADY && HTRANS[1];
    phase_next = irf_pkg::PH_IDLE;
    addr_next  = addr_reg;
    if (accept) begin
      addr_next  = HADDR[7:0];
      phase_next = HWRITE ? irf_pkg::PH_WR : irf_pkg::PH_RD;
    end
  end

  // ---------------------------------------------------------------
  // Pin edge detection
  // ---------------------------------------------------------------
  // Rising or falling per pin, only when the pin is an interrupt input
  always_comb begin
    for (int i = 0; i < irf_pkg::NPINS; i++) begin
      pin_hit[i] = ctrl_reg[irf_pkg::CTRL_PIN_LSB + i] &&
                   (edge_reg[i] ? (sync2_reg[i] && !prev_reg[i])
                                : (!sync2_reg[i] && prev_reg[i]));
    end
  end

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  // Flags: hardware sets, software clears by writing zero
  always_comb begin
    wr_en   = (phase_reg == irf_pkg::PH_WR);
    set_pri = 8'h00;
    set_sec = 8'h00;
    clr_wr  = 8'h00;
    set_pri[irf_pkg::BIT_DT]  = EVENTS.sleep_direct && ctrl_reg[irf_pkg::CTRL_DIRECT_TRANSITION_ENABLE];
    set_pri[irf_pkg::BIT_RTC] = EVENTS.rtc_ovf;
    set_pri[3:0]              = pin_hit;
    set_sec[irf_pkg::BIT_TB1] = EVENTS.tb1_ovf;
    enp_next  = enp_reg;
    ens_next  = ens_reg;
    edge_next = edge_reg;
    ctrl_next = ctrl_reg;
    // Writing zero clears, writing one leaves the flag alone
    if (wr_en) begin
      clr_wr = ~HWDATA[7:0];
    end
    pri_next = fn_flag(pri_reg, set_pri,
                       (wr_en && addr_reg == irf_pkg::OFS_PRI) ? clr_wr : 8'h00,
                       irf_pkg::PRI_MASK);
    sec_next = fn_flag(sec_reg, set_sec,
                       (wr_en && addr_reg == irf_pkg::OFS_SEC) ? clr_wr : 8'h00,
                       irf_pkg::SEC_MASK);
    // Plain configuration registers
    if (wr_en) begin
      case (addr_reg)
        irf_pkg::OFS_ENP: begin
          enp_next = HWDATA[7:0] & irf_pkg::PRI_MASK;
        end
        irf_pkg::OFS_ENS: begin
          ens_next = HWDATA[7:0] & irf_pkg::SEC_MASK;
        end
        irf_pkg::OFS_EDGE: begin
          edge_next = HWDATA[3:0];
        end
        irf_pkg::OFS_CTRL: begin
          ctrl_next = HWDATA[7:0] & irf_pkg::CTRL_MASK;
        end
        default: begin
          // Flag registers and unmapped writes: nothing more
        end
      endcase
    end
    // Request only for flags whose enable is set
    int_next = |((pri_next & enp_next) | (sec_next & ens_next));
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Built from next values so a write just before a read is seen
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (accept && !HWRITE) begin
      case (HADDR[7:0])
        irf_pkg::OFS_PRI: begin
          rdata_next[7:0] = fn_view(pri_next, irf_pkg::PRI_MASK, irf_pkg::PRI_ONES);
        end
        irf_pkg::OFS_SEC: begin
          rdata_next[7:0] = fn_view(sec_next, irf_pkg::SEC_MASK, irf_pkg::SEC_ONES);
        end
        irf_pkg::OFS_ENP: begin
          rdata_next[7:0] = fn_view(enp_next, irf_pkg::PRI_MASK, irf_pkg::PRI_ONES);
        end
        irf_pkg::OFS_ENS: begin
          rdata_next[7:0] = fn_view(ens_next, irf_pkg::SEC_MASK, irf_pkg::SEC_ONES);
        end
        irf_pkg::OFS_EDGE: begin
          rdata_next[3:0] = edge_next;
        end
        irf_pkg::OFS_CTRL: begin
          rdata_next[7:0] = ctrl_next;
        end
        default: begin
          // Unmapped: reads zero
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  // All flip-flops; asynchronous reset to constants
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg <= irf_pkg::PH_IDLE;
      addr_reg  <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'h1;
      resp_reg  <= irf_pkg::HRESP_OKAY;
      pri_reg   <= irf_pkg::RST_FLAGS;
      sec_reg   <= irf_pkg::RST_FLAGS;
      enp_reg   <= irf_pkg::RST_CFG;
      ens_reg   <= irf_pkg::RST_CFG;
      edge_reg  <= 4'h0;
      ctrl_reg  <= irf_pkg::RST_CFG;
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
      int_reg   <= 1'h0;
    end else begin
      phase_reg <= phase_next;
      addr_reg  <= addr_next;
      rdata_reg <= rdata_next;
      ready_reg <= 1'h1;
      resp_reg  <= irf_pkg::HRESP_OKAY;
      pri_reg   <= pri_next;
      sec_reg   <= sec_next;
      enp_reg   <= enp_next;
      ens_reg   <= ens_next;
      edge_reg  <= edge_next;
      ctrl_reg  <= ctrl_next;
      sync1_reg <= EXT_REQ_PIN;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      int_reg   <= int_next;
    end
  end

  // Outputs straight from flip-flops
  assign HRDATA    = rdata_reg;
  assign HREADYOUT = ready_reg;
  assign HRESP     = resp_reg;
  assign INT_REQ   = int_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Direct transition sets its flag only with the enable
  property p_dt_set;
    EVENTS.sleep_direct && ctrl_reg[irf_pkg::CTRL_DIRECT_TRANSITION_ENABLE] |=> pri_reg[irf_pkg::BIT_DT];
  endproperty
  a_dt_set: assert property (p_dt_set) else $error("direct flag not set");

  // Clock overflow sets its flag
  property p_rtc_set;
    EVENTS.rtc_ovf |=> pri_reg[irf_pkg::BIT_RTC];
  endproperty
  a_rtc_set: assert property (p_rtc_set) else $error("rtc flag not set");

  // Pin 0 rising edge on a configured pin sets flag 0 one edge on
  property p_pin_rise;
    ctrl_reg[4] && edge_reg[0] && $rose(sync2_reg[0]) |=> pri_reg[0];
  endproperty
  a_pin_rise: assert property (p_pin_rise) else $error("pin rise missed");

  // Falling edge selected: a rise alone never sets the flag
  property p_pin_fall_only;
    !pri_reg[1] && !edge_reg[1] && !(!sync2_reg[1] && prev_reg[1]) |=> !pri_reg[1];
  endproperty
  a_pin_fall_only: assert property (p_pin_fall_only) else $error("wrong edge");

  // Timer B1 overflow sets secondary bit 5
  property p_tb1_set;
    EVENTS.tb1_ovf |=> sec_reg[irf_pkg::BIT_TB1];
  endproperty
  a_tb1_set: assert property (p_tb1_set) else $error("tb1 flag not set");

  // Zero written with no event clears the flag
  property p_clear;
    phase_reg == irf_pkg::PH_WR && addr_reg == irf_pkg::OFS_PRI && !HWDATA[irf_pkg::BIT_RTC]
      && !EVENTS.rtc_ovf |=> !pri_reg[irf_pkg::BIT_RTC];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  // Fixed bits of the flag registers on read
  property p_fixed_read;
    phase_reg == irf_pkg::PH_RD && addr_reg == irf_pkg::OFS_SEC
      |-> HRDATA[7:6] == 2'b00 && HRDATA[4:0] == 5'h1f && HRDATA[31:8] == 24'h0;
  endproperty
  a_fixed_read: assert property (p_fixed_read) else $error("secondary fixed bits");

  property p_fixed_pri;
    phase_reg == irf_pkg::PH_RD && addr_reg == irf_pkg::OFS_PRI |-> HRDATA[5:4] == 2'b11;
  endproperty
  a_fixed_pri: assert property (p_fixed_pri) else $error("primary fixed bits");

  // Request output follows flags and enables
  property p_int;
    INT_REQ == |((pri_reg & enp_reg) | (sec_reg & ens_reg));
  endproperty
  a_int: assert property (p_int) else $error("request mismatch");

  // Set beats a simultaneous clear; one written keeps a set flag
  property p_set_wins;
    phase_reg == irf_pkg::PH_WR && addr_reg == irf_pkg::OFS_SEC
      && (EVENTS.tb1_ovf || sec_reg[irf_pkg::BIT_TB1])
      && (EVENTS.tb1_ovf || HWDATA[irf_pkg::BIT_TB1]) |=> sec_reg[irf_pkg::BIT_TB1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost");

  // Main scenarios
  c_dt: cover property (EVENTS.sleep_direct && ctrl_reg[0]);
  c_int: cover property ($rose(INT_REQ));
  c_race: cover property (phase_reg == irf_pkg::PH_WR && addr_reg == irf_pkg::OFS_PRI
                          && EVENTS.rtc_ovf);

endmodule : irf_top

//--- testbench/irf_src_model.sv
// Event source model: on-chip overflow and transition pulses, external request pins
module irf_src_model (
  input  wire logic         clk,   // System clock
  output irf_pkg::irf_evt_t evts,  // One-cycle event pulses
  output logic [3:0]        pins   // External request pin levels
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  // Quiet sources at time zero
  initial begin
    evts = '0;
    pins = 4'h0;
  end

  // Pulse chosen events for one cycle; mask is {sleep_direct, rtc_ovf, tb1_ovf}
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    evts <= irf_pkg::irf_evt_t'(m);
    @(posedge clk);
    evts <= '0;
  endtask : pulse

  // Move the pins to new levels, held until the next call
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk);
    pins <= v;
  endtask : set_pins
endmodule : irf_src_model

//--- testbench/tb_irf_top.sv
// Testbench: register bus, event and pin scenarios for the request flag block
module tb_irf_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              clk, reset_n, hsel, hwrite, int_req, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [3:0]        pins;
  irf_pkg::irf_evt_t evts;
  int                errors, check_count;

  // Design and event source model
  irf_top uut (.CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_REQ_PIN(pins), .EVENTS(evts),
    .INT_REQ(int_req));
  irf_src_model src (.clk(clk), .evts(evts), .pins(pins));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= irf_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Read and compare one register
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  // Check the request line one cycle on
  task automatic ichk(input logic exp);
    @(posedge clk);
    #1 chk({31'h0, int_req}, {31'h0, exp});
  endtask : ichk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, fixed bits and an unmapped read
  task automatic t_reset;
    rchk(irf_pkg::OFS_PRI, 32'h30);
    rchk(irf_pkg::OFS_SEC, 32'h1f);
    rchk(8'h18, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Overflow flags: set, kept by writing one, cleared by writing zero
  task automatic t_timers;
    src.pulse(3'b010);
    src.pulse(3'b001);
    rchk(irf_pkg::OFS_PRI, 32'h70);
    rchk(irf_pkg::OFS_SEC, 32'h3f);
    bus(1'b1, irf_pkg::OFS_PRI, 32'hff);
    rchk(irf_pkg::OFS_PRI, 32'h70);
    bus(1'b1, irf_pkg::OFS_PRI, 32'h0);
    rchk(irf_pkg::OFS_PRI, 32'h30);
    bus(1'b1, irf_pkg::OFS_SEC, 32'h0);
    rchk(irf_pkg::OFS_SEC, 32'h1f);
    $display("test timers done");
  endtask : t_timers

  // Direct transition ignored until enabled
  task automatic t_direct;
    src.pulse(3'b100);
    rchk(irf_pkg::OFS_PRI, 32'h30);
    bus(1'b1, irf_pkg::OFS_CTRL, 32'h01);
    src.pulse(3'b100);
    rchk(irf_pkg::OFS_PRI, 32'hb0);
    bus(1'b1, irf_pkg::OFS_PRI, 32'h0);
    $display("test direct done");
  endtask : t_direct

  // Pins 0 and 2 rising, 1 and 3 falling, then pin function off
  task automatic t_pins;
    bus(1'b1, irf_pkg::OFS_CTRL, 32'hf0);
    bus(1'b1, irf_pkg::OFS_EDGE, 32'h05);
    src.set_pins(4'hf);
    repeat (4) @(posedge clk);
    rchk(irf_pkg::OFS_PRI, 32'h35);
    src.set_pins(4'h0);
    repeat (4) @(posedge clk);
    rchk(irf_pkg::OFS_PRI, 32'h3f);
    bus(1'b1, irf_pkg::OFS_PRI, 32'h0);
    bus(1'b1, irf_pkg::OFS_CTRL, 32'h00);
    src.set_pins(4'hf);
    repeat (4) @(posedge clk);
    rchk(irf_pkg::OFS_PRI, 32'h30);
    $display("test pins done");
  endtask : t_pins

  // Request line follows enabled flags only
  task automatic t_irq;
    bus(1'b1, irf_pkg::OFS_ENP, 32'h40);
    src.pulse(3'b010);
    ichk(1'b1);
    bus(1'b1, irf_pkg::OFS_ENP, 32'h0);
    ichk(1'b0);
    bus(1'b1, irf_pkg::OFS_PRI, 32'h0);
    bus(1'b1, irf_pkg::OFS_ENS, 32'h20);
    src.pulse(3'b001);
    ichk(1'b1);
    bus(1'b1, irf_pkg::OFS_SEC, 32'h0);
    ichk(1'b0);
    $display("test irq done");
  endtask : t_irq

  // Event and clearing write in one cycle: the set wins; writing one keeps
  task automatic t_race;
    fork
      bus(1'b1, irf_pkg::OFS_PRI, 32'h0);
      begin
        @(posedge clk);
        src.pulse(3'b010);
      end
    join
    rchk(irf_pkg::OFS_PRI, 32'h70);
    fork
      bus(1'b1, irf_pkg::OFS_SEC, 32'h0);
      begin
        @(posedge clk);
        src.pulse(3'b001);
      end
    join
    rchk(irf_pkg::OFS_SEC, 32'h3f);
    bus(1'b1, irf_pkg::OFS_SEC, 32'hff);
    rchk(irf_pkg::OFS_SEC, 32'h3f);
    $display("test race done");
  endtask : t_race

  // Reset in mid-run drops flags set by all three on-chip events and the request
  task automatic t_rerst;
    bus(1'b1, irf_pkg::OFS_CTRL, 32'h01);
    src.pulse(3'b111);
    rchk(irf_pkg::OFS_PRI, 32'hf0);
    ichk(1'b1);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    ichk(1'b0);
    rchk(irf_pkg::OFS_PRI, 32'h30);
    rchk(irf_pkg::OFS_SEC, 32'h1f);
    $display("test mid-run reset done");
  endtask : t_rerst

  // ---------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  // ---------------------------------------------------------------
  // Counts and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard at 5000 cycles, well beyond the fewer than two hundred cycles of the tests
  initial begin
    #20000;
    errors++;
    give_verdict();
  end

  // Reset, then each scenario in turn
  initial begin
    errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    // Select low; the other bus fields are first set by a transfer
    hsel = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_timers();
    t_direct();
    t_pins();
    t_irq();
    t_race();
    t_rerst();
    give_verdict();
  end
endmodule : tb_irf_top
